// File: isp_pkg.sv
// Purpose: shared constants for the host serial port, both ends.
// Assumes: sys clock 20 MHz; serial clock made by the host from it.
// Notes: the mode bit resets to 0, giving 4-wire operation after reset.
`default_nettype none
package isp_pkg;
  localparam int unsigned ISP_BYTE_W = 8;
  localparam int unsigned ISP_IDX_W = 6;
  localparam int unsigned ISP_REGS = 64;
  localparam int unsigned ISP_RD_BIT = 7;
  localparam int unsigned ISP_INC_BIT = 6;
  localparam int unsigned ISP_MODE_BIT = 7;
  localparam logic [5:0] ISP_CTRL_IDX = 6'h02;
  localparam logic [7:0] ISP_CTRL_RST = 8'h00;
  // serial clock timing
  localparam int unsigned ISP_SYS_PERIOD_NS = 50;
  localparam int unsigned ISP_SCLK_MIN_NS = 100;
  localparam int unsigned ISP_SCLK_PERIOD_NS = 400;
  localparam int unsigned ISP_HALF_CYC =
    (ISP_SCLK_PERIOD_NS + 2 * ISP_SYS_PERIOD_NS - 1) / (2 * ISP_SYS_PERIOD_NS);
  localparam int unsigned ISP_DIV_W = 4;
  // host command port
  localparam int unsigned ISP_HADDR_W = 5;
  localparam logic [4:0] ISP_HREG_CMD = 5'h00;
  localparam logic [4:0] ISP_HREG_STAT = 5'h01;
  localparam logic [4:0] ISP_HREG_MODE = 5'h02;
  localparam logic [4:0] ISP_HREG_BUF = 5'h10;
  localparam int unsigned ISP_BUF_DEPTH = 16;
  localparam int unsigned ISP_CMD_CNT_LSB = 8;
  localparam int unsigned ISP_CMD_START_BIT = 12;
  typedef enum logic [1:0] {
    ISP_ST_IDLE = 2'b00,
    ISP_ST_SETUP = 2'b01,
    ISP_ST_SHIFT = 2'b10,
    ISP_ST_GAP = 2'b11
  } isp_state_t;
endpackage
`default_nettype wire

// File: isp_spi_if.sv
// Purpose: serial link between host and device ends.
// Assumes: undriven lines read high, as with a weak pull-up.
// Notes: shared data pin and output pin are resolved here from enables.
`default_nettype none
interface isp_spi_if;
  logic cs_n;
  logic sclk;
  logic host_dq;
  logic host_dq_oe;
  logic dev_dq;
  logic dev_dq_oe;
  logic dev_so;
  logic dev_so_oe;
  logic dq;
  logic so;
  assign dq = dev_dq_oe ? dev_dq : (host_dq_oe ? host_dq : 1'b1);
  assign so = dev_so_oe ? dev_so : 1'b1;
  modport host (
    output cs_n,
    output sclk,
    output host_dq,
    output host_dq_oe,
    input dq,
    input so
  );
  modport device (
    input cs_n,
    input sclk,
    input dq,
    output dev_dq,
    output dev_dq_oe,
    output dev_so,
    output dev_so_oe
  );
endinterface
`default_nettype wire

// File: isp_dev_end.sv
// Purpose: device end of the serial port with its register array.
// Assumes: link logic runs on the serial clock; chip select is active low.
// Notes: user side gets the wiring mode and every register write, in sys clock.
// Contract
// - 4-wire: cs, clock, data in, data out
// - 3-wire: one shared bidirectional data line
// - shared pin role follows wiring mode
// - mode bit 7 of control register; 1=3-wire
// - after reset 4-wire, mode bit 0
// - sample incoming data on rising clock
// - master changes data on falling clock
// - all bytes most significant bit first
// - address byte: read, inc, 6-bit index
// - read flag 1 reads, 0 writes
// - address byte then data bytes, burst
// - inc set advances index each byte
// - inc clear keeps same index
// - single byte transfers send inc 0
// - control registers written singly only; a burst write into the control register is still accepted
// - host reads and writes configuration registers
// - release data line when cs rises
//
// The placing of the registers and the plain strobed port were decided locally.
`default_nettype none
module isp_dev_end (
  isp_spi_if.device link,
  input wire logic i_clk_sys,
  input wire logic i_sys_rst,
  input wire logic i_ce,
  output logic o_wire3,
  output logic o_wr_stb,
  output logic [5:0] o_wr_index,
  output logic [7:0] o_wr_data
);
  logic rst_q;
  logic [7:0] mem [0:isp_pkg::ISP_REGS-1];
  logic [7:0] ctrl_reg;
  logic wire3;
  logic [2:0] bit_cnt;
  logic addr_ph;
  logic rd_flag;
  logic inc_flag;
  logic reading;
  logic [5:0] index;
  logic [6:0] shift;
  logic [7:0] tx;
  logic out_bit;
  logic drv;
  logic rx_bit;
  logic [7:0] rx_byte;
  logic byte_end;
  logic [5:0] next_index;
  logic wr_now;
  logic wr_tgl;
  logic [5:0] wr_idx;
  logic [7:0] wr_dat;
  logic mode_s1;
  logic mode_s2;
  logic tgl_s1;
  logic tgl_s2;
  logic tgl_s3;

  // read decode, used for the first byte of a read and for each follow-on byte
  function automatic logic [7:0] rd_value(input logic [5:0] idx);
    logic [7:0] v;
    v = mem[idx];
    if (idx == isp_pkg::ISP_CTRL_IDX) begin
      v = ctrl_reg;
    end
    return v;
  endfunction

  // reset is registered so the link flops see a clean level from one flop
  always_ff @(posedge i_clk_sys) begin
    rst_q <= i_sys_rst;
  end

  assign wire3 = ctrl_reg[isp_pkg::ISP_MODE_BIT];
  assign rx_bit = link.dq;
  assign rx_byte = {shift, rx_bit};
  assign byte_end = (bit_cnt == 3'h7);
  assign next_index = inc_flag ? 6'(index + 6'h01) : index;
  assign wr_now = byte_end && !addr_ph && !rd_flag;

  // framing: chip select high clears it without any clock edge
  always_ff @(posedge link.sclk or posedge link.cs_n) begin
    if (link.cs_n) begin
      bit_cnt <= 3'h0;
      addr_ph <= 1'b1;
      reading <= 1'b0;
      rd_flag <= 1'b0;
      inc_flag <= 1'b0;
      index <= 6'h00;
      shift <= 7'h00;
    end else begin
      bit_cnt <= 3'(bit_cnt + 3'h1);
      shift <= {shift[5:0], rx_bit};
      if (byte_end && addr_ph) begin
        addr_ph <= 1'b0;
        rd_flag <= rx_byte[isp_pkg::ISP_RD_BIT];
        inc_flag <= rx_byte[isp_pkg::ISP_INC_BIT];
        index <= rx_byte[isp_pkg::ISP_IDX_W-1:0];
        reading <= rx_byte[isp_pkg::ISP_RD_BIT];
      end else if (byte_end) begin
        index <= next_index;
      end
    end
  end

  // transmit shifter: loaded at each byte end of a read, shifted between
  always_ff @(posedge link.sclk or posedge link.cs_n) begin
    if (link.cs_n) begin
      tx <= 8'h00;
    end else if (byte_end && addr_ph) begin
      tx <= rd_value(rx_byte[isp_pkg::ISP_IDX_W-1:0]);
    end else if (byte_end && reading) begin
      tx <= rd_value(next_index);
    end else if (reading) begin
      tx <= {tx[6:0], 1'b0};
    end
  end

  // output changes on the falling edge so the master sees it stable
  always_ff @(negedge link.sclk or posedge link.cs_n) begin
    if (link.cs_n) begin
      drv <= 1'b0;
      out_bit <= 1'b0;
    end else begin
      drv <= reading;
      out_bit <= tx[7];
    end
  end

  assign link.dev_so = out_bit;
  assign link.dev_so_oe = drv && !wire3;
  assign link.dev_dq = out_bit;
  assign link.dev_dq_oe = drv && wire3;

  // register array has no reset; only the control register must start known
  always_ff @(posedge link.sclk) begin
    if (wr_now && index != isp_pkg::ISP_CTRL_IDX) begin
      mem[index] <= rx_byte;
    end
  end

  // a burst write into the control register is not protected against
  always_ff @(posedge link.sclk or posedge rst_q) begin
    if (rst_q) begin
      ctrl_reg <= isp_pkg::ISP_CTRL_RST;
    end else if (wr_now && index == isp_pkg::ISP_CTRL_IDX) begin
      ctrl_reg <= rx_byte;
    end
  end

  // write event to the sys side: toggle plus data held until the next write
  always_ff @(posedge link.sclk or posedge rst_q) begin
    if (rst_q) begin
      wr_tgl <= 1'b0;
      wr_idx <= 6'h00;
      wr_dat <= 8'h00;
    end else if (wr_now) begin
      wr_tgl <= !wr_tgl;
      wr_idx <= index;
      wr_dat <= rx_byte;
    end
  end

  // sys side: mode level through three flops
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      mode_s1 <= 1'b0;
      mode_s2 <= 1'b0;
      o_wire3 <= 1'b0;
    end else if (i_ce) begin
      mode_s1 <= wire3;
      mode_s2 <= mode_s1;
      o_wire3 <= mode_s2;
    end
  end

  // sys side: write toggle through two flops, then edge detect
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      tgl_s1 <= 1'b0;
      tgl_s2 <= 1'b0;
      tgl_s3 <= 1'b0;
    end else if (i_ce) begin
      tgl_s1 <= wr_tgl;
      tgl_s2 <= tgl_s1;
      tgl_s3 <= tgl_s2;
    end
  end

  // data is safe to take: it settled two sys cycles before the toggle showed
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      o_wr_stb <= 1'b0;
      o_wr_index <= 6'h00;
      o_wr_data <= 8'h00;
    end else if (i_ce) begin
      o_wr_stb <= tgl_s2 ^ tgl_s3;
      if (tgl_s2 ^ tgl_s3) begin
        o_wr_index <= wr_idx;
        o_wr_data <= wr_dat;
      end
    end
  end
endmodule
`default_nettype wire

// File: isp_host_end.sv
// Purpose: host end, a serial master run by software through a small port.
// Assumes: serial clock is divided from the sys clock, idling high.
// Notes: software must set the mode here to match the device's mode bit.
`default_nettype none
module isp_host_end (
  isp_spi_if.host link,
  input wire logic i_clk_sys,
  input wire logic i_sys_rst,
  input wire logic i_ce,
  input wire logic [4:0] i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [15:0] o_rdata
);
  localparam logic [3:0] HALF = 4'(isp_pkg::ISP_HALF_CYC);
  localparam logic [3:0] LAST = 4'(2 * isp_pkg::ISP_HALF_CYC - 1);
  isp_pkg::isp_state_t state;
  logic [7:0] buf_mem [0:isp_pkg::ISP_BUF_DEPTH-1];
  logic mode3;
  logic c_rd;
  logic c_inc;
  logic [5:0] c_idx;
  logic [3:0] c_last;
  logic [3:0] div;
  logic [2:0] bit_cnt;
  logic [4:0] byte_cnt;
  logic [7:0] tx;
  logic [7:0] rx;
  logic so_s1, so_s2, dq_s1, dq_s2;
  logic miso;
  logic start;
  logic store;
  logic byte_done;

  assign start = i_wr && i_addr == isp_pkg::ISP_HREG_CMD
    && i_wdata[isp_pkg::ISP_CMD_START_BIT] && state == isp_pkg::ISP_ST_IDLE;
  assign byte_done = state == isp_pkg::ISP_ST_SHIFT && div == LAST && bit_cnt == 3'h7;
  assign store = byte_done && byte_cnt != 5'h00 && c_rd;
  assign miso = mode3 ? dq_s2 : so_s2;

  // pins from the device pass two flops before use
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      so_s1 <= 1'b1;
      so_s2 <= 1'b1;
      dq_s1 <= 1'b1;
      dq_s2 <= 1'b1;
    end else if (i_ce) begin
      so_s1 <= link.so;
      so_s2 <= so_s1;
      dq_s1 <= link.dq;
      dq_s2 <= dq_s1;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      mode3 <= 1'b0;
    end else if (i_ce && i_wr && i_addr == isp_pkg::ISP_HREG_MODE) begin
      mode3 <= i_wdata[0];
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_ce && store) begin
      buf_mem[4'(byte_cnt - 5'h01)] <= rx;
    end else if (i_ce && i_wr && i_addr[4]) begin
      buf_mem[i_addr[3:0]] <= i_wdata[7:0];
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      o_rdata <= 16'h0000;
    end else if (i_ce && i_rd) begin
      o_rdata <= 16'h0000;
      if (i_addr[4]) begin
        o_rdata <= {8'h00, buf_mem[i_addr[3:0]]};
      end else if (i_addr == isp_pkg::ISP_HREG_STAT) begin
        o_rdata <= {15'h0000, state != isp_pkg::ISP_ST_IDLE};
      end else if (i_addr == isp_pkg::ISP_HREG_MODE) begin
        o_rdata <= {15'h0000, mode3};
      end
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      state <= isp_pkg::ISP_ST_IDLE;
      link.cs_n <= 1'b1;
      link.sclk <= 1'b1;
      link.host_dq <= 1'b0;
      link.host_dq_oe <= 1'b0;
      {c_rd, c_inc, c_idx, c_last} <= 12'h000;
      div <= 4'h0;
      bit_cnt <= 3'h0;
      byte_cnt <= 5'h00;
      tx <= 8'h00;
      rx <= 8'h00;
    end else if (i_ce) begin
      unique case (state)
        isp_pkg::ISP_ST_IDLE: begin
          if (start) begin
            c_rd <= i_wdata[isp_pkg::ISP_RD_BIT];
            c_inc <= i_wdata[isp_pkg::ISP_INC_BIT];
            c_idx <= i_wdata[5:0];
            c_last <= i_wdata[isp_pkg::ISP_CMD_CNT_LSB +: 4];
            link.cs_n <= 1'b0;
            div <= 4'h0;
            state <= isp_pkg::ISP_ST_SETUP;
          end
        end
        isp_pkg::ISP_ST_SETUP: begin
          div <= 4'(div + 4'h1);
          if (div == 4'(HALF - 4'h1)) begin
            div <= 4'h0;
            bit_cnt <= 3'h0;
            byte_cnt <= 5'h00;
            tx <= {c_rd, c_inc, c_idx};
            state <= isp_pkg::ISP_ST_SHIFT;
          end
        end
        isp_pkg::ISP_ST_SHIFT: begin
          div <= (div == LAST) ? 4'h0 : 4'(div + 4'h1);
          if (div == 4'h0) begin
            link.sclk <= 1'b0;
            link.host_dq <= tx[7];
            link.host_dq_oe <= !(mode3 && c_rd && byte_cnt != 5'h00);
            tx <= {tx[6:0], 1'b0};
          end
          if (div == HALF) begin
            link.sclk <= 1'b1;
            rx <= {rx[6:0], miso};
          end
          if (div == LAST) begin
            bit_cnt <= 3'(bit_cnt + 3'h1);
          end
          if (byte_done) begin
            byte_cnt <= 5'(byte_cnt + 5'h01);
            tx <= buf_mem[byte_cnt[3:0]];
            if (byte_cnt == 5'({1'b0, c_last} + 5'h01)) begin
              state <= isp_pkg::ISP_ST_GAP;
              link.cs_n <= 1'b1;
              link.host_dq_oe <= 1'b0;
              div <= 4'h0;
            end
          end
        end
        isp_pkg::ISP_ST_GAP: begin
          div <= 4'(div + 4'h1);
          if (div == 4'(HALF - 4'h1)) begin
            state <= isp_pkg::ISP_ST_IDLE;
          end
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// File: isp_link_chk.sv
// Purpose: link checks between the host and device ends.
// Assumes: sampled on the sys clock, from which the serial clock is divided.
// Notes: counts serial rising edges per frame to place the read turn-around.
`default_nettype none
module isp_link_chk (
  input wire logic i_clk_sys,
  input wire logic i_sys_rst,
  input wire logic i_cs_n,
  input wire logic i_sclk,
  input wire logic i_host_dq,
  input wire logic i_host_dq_oe,
  input wire logic i_dev_dq,
  input wire logic i_dev_dq_oe,
  input wire logic i_dev_so,
  input wire logic i_dev_so_oe
);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (i_sys_rst);
  logic sclk_q;
  logic [7:0] rise_cnt;
  always_ff @(posedge i_clk_sys) begin
    sclk_q <= i_sclk;
  end
  // cleared by chip select, so a second frame never inherits a count
  always_ff @(posedge i_clk_sys) begin
    if (i_cs_n) begin
      rise_cnt <= 8'h00;
    end else if (i_sclk && !sclk_q) begin
      rise_cnt <= rise_cnt + 8'h01;
    end
  end
  sequence lead_in;
    i_sclk[*4];
  endsequence
  // eight sys cycles per bit: four samples low, then high
  sequence low_half;
    !i_sclk[*4] ##1 i_sclk;
  endsequence
  idle_clock_a: assert property (i_cs_n && $past(i_cs_n) |-> i_sclk)
    else $error("serial clock moved outside a frame");
  lead_in_a: assert property ($fell(i_cs_n) |-> lead_in)
    else $error("serial clock fell too soon after select");
  clock_low_a: assert property ($fell(i_sclk) |-> low_half)
    else $error("serial clock low phase has wrong length");
  host_data_a: assert property (!i_cs_n && $past(!i_cs_n) && i_host_dq_oe
    && $changed(i_host_dq) |-> $fell(i_sclk))
    else $error("host data changed away from a falling edge");
  dev_data_a: assert property (i_dev_so_oe && $past(i_dev_so_oe) && $changed(i_dev_so)
    |-> $fell(i_sclk))
    else $error("device data changed away from a falling edge");
  shared_data_a: assert property (i_dev_dq_oe && $past(i_dev_dq_oe) && $changed(i_dev_dq)
    |-> $fell(i_sclk))
    else $error("device shared data changed away from a falling edge");
  dq_contention_a: assert property (!(i_dev_dq_oe && i_host_dq_oe))
    else $error("both ends drive the shared data line");
  oe_release_a: assert property (i_cs_n |-> !i_dev_dq_oe && !i_dev_so_oe)
    else $error("device drives a data line while deselected");
  one_driver_a: assert property (!(i_dev_dq_oe && i_dev_so_oe))
    else $error("device drives both data lines");
  turn_so_a: assert property ($rose(i_dev_so_oe) |-> $fell(i_sclk) && rise_cnt == 8'h08)
    else $error("output line driven at the wrong edge");
  turn_dq_a: assert property ($rose(i_dev_dq_oe) |-> $fell(i_sclk) && rise_cnt == 8'h08)
    else $error("shared line driven at the wrong edge");
endmodule
`default_nettype wire

// File: imu_host_spi_slave_port_bench.sv
// Purpose: drives the host end, watches the device end and the link.
// Assumes: host command port layout as set by the designer.
// Notes: device writes are logged from the strobe and compared in order.
`default_nettype none
module imu_host_spi_slave_port_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_clk_sys;
  logic i_sys_rst;
  logic [4:0] i_addr;
  logic [15:0] i_wdata;
  logic [15:0] o_rdata;
  logic i_wr;
  logic i_rd;
  logic i_ce;
  logic o_wire3;
  logic o_wr_stb;
  logic [5:0] o_wr_index;
  logic [7:0] o_wr_data;
  logic [13:0] wlog[$];
  int err_count = 0;
  int total_checks = 0;
  int cyc = 0;
  isp_spi_if link ();
  isp_host_end isp_host_end_inst (.link(link), .i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst),
    .i_ce(i_ce), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
    .o_rdata(o_rdata));
  isp_dev_end isp_dev_end_inst (.link(link), .i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst),
    .i_ce(i_ce), .o_wire3(o_wire3), .o_wr_stb(o_wr_stb), .o_wr_index(o_wr_index),
    .o_wr_data(o_wr_data));
  isp_link_chk isp_link_chk_inst (.i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst),
    .i_cs_n(link.cs_n), .i_sclk(link.sclk), .i_host_dq(link.host_dq),
    .i_host_dq_oe(link.host_dq_oe), .i_dev_dq(link.dev_dq), .i_dev_dq_oe(link.dev_dq_oe),
    .i_dev_so(link.dev_so), .i_dev_so_oe(link.dev_so_oe));
  initial begin
    i_clk_sys = 1'b0;
    forever #25 i_clk_sys = ~i_clk_sys;
  end
  // the busy poll gives up after 400 reads; this caps the whole run at 40000 cycles
  always @(posedge i_clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      err_count++;
      stop_test();
    end
  end
  always @(posedge i_clk_sys) begin
    if (o_wr_stb === 1'b1) begin
      wlog.push_back({o_wr_index, o_wr_data});
    end
  end
  task automatic stop_test();
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge i_clk_sys);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clk_sys);
    i_wr <= 1'b0;
  endtask
  task automatic rd(input logic [4:0] a, output logic [15:0] d);
    @(posedge i_clk_sys);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk_sys);
    i_rd <= 1'b0;
    #1 d = o_rdata;
  endtask
  task automatic put(input logic [4:0] k, input logic [7:0] b);
    wr(isp_pkg::ISP_HREG_BUF + k, {8'h00, b});
  endtask
  task automatic xfer(input logic rdf, input logic inc, input logic [5:0] idx,
    input logic [3:0] nm1);
    logic [15:0] s;
    int k;
    wr(isp_pkg::ISP_HREG_CMD, {3'h0, 1'b1, nm1, rdf, inc, idx});
    s = 16'h0001;
    k = 0;
    while (s[0] !== 1'b0 && k < 400) begin
      rd(isp_pkg::ISP_HREG_STAT, s);
      k++;
    end
    chk({15'h0000, s[0]}, 16'h0000);
    repeat (8) @(posedge i_clk_sys);
  endtask
  task automatic expw(input logic [5:0] i, input logic [7:0] d);
    chk({2'b00, (wlog.size() > 0) ? wlog.pop_front() : 14'h3FFF}, {2'b00, i, d});
  endtask
  task automatic getb(input logic [4:0] k, input logic [7:0] e);
    logic [15:0] s;
    rd(isp_pkg::ISP_HREG_BUF + k, s);
    chk({8'h00, s[7:0]}, {8'h00, e});
  endtask
  task automatic t_reset();
    logic [15:0] s;
    chk({15'h0000, o_wire3}, 16'h0000);
    rd(isp_pkg::ISP_HREG_MODE, s);
    chk(s, 16'h0000);
    rd(5'h08, s);
    chk(s, 16'h0000);
  endtask
  task automatic t_single();
    put(5'h00, 8'hA5);
    xfer(1'b0, 1'b0, 6'h05, 4'h0);
    expw(6'h05, 8'hA5);
    xfer(1'b1, 1'b0, 6'h05, 4'h0);
    getb(5'h00, 8'hA5);
  endtask
  // the burst starts one below the top index to cross the wrap
  task automatic t_inc();
    put(5'h00, 8'hC3);
    put(5'h01, 8'h3C);
    put(5'h02, 8'h96);
    xfer(1'b0, 1'b1, 6'h3E, 4'h2);
    expw(6'h3E, 8'hC3);
    expw(6'h3F, 8'h3C);
    expw(6'h00, 8'h96);
    xfer(1'b1, 1'b1, 6'h3E, 4'h2);
    getb(5'h00, 8'hC3);
    getb(5'h01, 8'h3C);
    getb(5'h02, 8'h96);
  endtask
  task automatic t_same();
    put(5'h00, 8'h11);
    put(5'h01, 8'h22);
    xfer(1'b0, 1'b0, 6'h10, 4'h1);
    expw(6'h10, 8'h11);
    expw(6'h10, 8'h22);
    xfer(1'b1, 1'b0, 6'h10, 4'h1);
    getb(5'h00, 8'h22);
    getb(5'h01, 8'h22);
  endtask
  task automatic t_wire3();
    put(5'h00, 8'h80);
    xfer(1'b0, 1'b0, isp_pkg::ISP_CTRL_IDX, 4'h0);
    expw(isp_pkg::ISP_CTRL_IDX, 8'h80);
    chk({15'h0000, o_wire3}, 16'h0001);
    wr(isp_pkg::ISP_HREG_MODE, 16'h0001);
    put(5'h00, 8'h5A);
    xfer(1'b0, 1'b0, 6'h07, 4'h0);
    expw(6'h07, 8'h5A);
    xfer(1'b1, 1'b0, 6'h07, 4'h0);
    getb(5'h00, 8'h5A);
    xfer(1'b1, 1'b0, isp_pkg::ISP_CTRL_IDX, 4'h0);
    getb(5'h00, 8'h80);
    put(5'h00, 8'h00);
    xfer(1'b0, 1'b0, isp_pkg::ISP_CTRL_IDX, 4'h0);
    expw(isp_pkg::ISP_CTRL_IDX, 8'h00);
    chk({15'h0000, o_wire3}, 16'h0000);
    wr(isp_pkg::ISP_HREG_MODE, 16'h0000);
    xfer(1'b1, 1'b0, 6'h05, 4'h0);
    getb(5'h00, 8'hA5);
  endtask
  // a mode write while the enable is low must leave the mode untouched
  task automatic t_ce();
    logic [15:0] s;
    @(posedge i_clk_sys);
    i_ce <= 1'b0;
    wr(isp_pkg::ISP_HREG_MODE, 16'h0001);
    i_ce <= 1'b1;
    rd(isp_pkg::ISP_HREG_MODE, s);
    chk(s, 16'h0000);
  endtask
  initial begin
    i_sys_rst = 1'b1;
    i_addr = 5'h00;
    i_wdata = 16'h0000;
    i_wr = 1'b0;
    i_rd = 1'b0;
    i_ce = 1'b1;
    repeat (10) @(posedge i_clk_sys);
    i_sys_rst <= 1'b0;
    t_reset();
    t_single();
    t_inc();
    t_same();
    t_wire3();
    t_ce();
    stop_test();
  end
endmodule
`default_nettype wire
